// >>> test_trigger_timing_sync.sv
// self-checking bench for the trigger timing block
// assumes shortened start latencies; holdoff stays at full length
`timescale 1ns/100ps
`default_nettype none
module test_trigger_timing_sync;
  localparam int LF = 20;
  localparam int LS = 16;
  localparam int HO = 57;
  logic               core_clk;
  logic               rst_b;
  logic               wave_end;
  logic               jump_in;
  logic               clk_o;
  logic               sync_o;
  logic               busy;
  logic               hold;
  logic [3:0]         start;
  logic [3:0]         jump;
  tts_pkg::tts_cfg_t  cfg;
  tts_pkg::tts_trig_t trig;
  int                 fails = 0;
  int                 n_compared = 0;

  tts_trigger_sync #(.LAT_FAST(LF), .LAT_SLOW(LS)) dut (
    .CORE_CLK(core_clk), .RST_B(rst_b), .TRIG(trig), .CFG(cfg),
    .WAVE_END(wave_end), .JUMP_IN(jump_in), .CLK_OUT(clk_o),
    .SYNC_CLK_OUT(sync_o), .UNIT_START(start), .UNIT_JUMP(jump),
    .BUSY(busy), .HOLDOFF(hold));
  tts_trig_src src (.clk(core_clk), .sync_clk(sync_o), .cfg(cfg),
    .trig(trig));

  // *************************************************************
  // helpers
  // *************************************************************
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'h1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_start(input int lim, output int n);
    n = 0;
    while (start === 4'h0 && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic wait_sync(input logic v, output int n);
    n = 0;
    while (sync_o !== v && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  task automatic finish_wave();
    int n;
    int m;
    wave_end = 1'h1;
    tick(1);
    wave_end = 1'h0;
    n = 0;
    while (hold !== 1'h1 && n < 3) begin
      tick(1);
      n++;
    end
    // a crossing inside holdoff must be dropped
    src.set(2, 1'h1);
    tick(2);
    src.set(2, 1'h0);
    m = 2;
    while (hold === 1'h1 && m < 100) begin
      tick(1);
      m++;
    end
    chk(m == HO, "holdoff length");
    // span a whole slow sampling period so a held trigger would show
    wait_start(tts_pkg::SYNC_PERIOD + LF, n);
    chk(n == tts_pkg::SYNC_PERIOD + LF, "holdoff trigger played");
    chk(busy === 1'h0, "busy after holdoff");
  endtask

  // *************************************************************
  // scenarios
  // *************************************************************
  task automatic test_clocks();
    int n;
    logic c;
    c = clk_o;
    tick(1);
    chk(clk_o === ~c, "clock out stuck");
    wait_sync(1'h0, n);
    wait_sync(1'h1, n);
    wait_sync(1'h0, n);
    chk(n == 80, "sync clock high time");
    wait_sync(1'h1, n);
    chk(n == 80, "sync clock low time");
    $display("clock test done");
  endtask
  task automatic test_fast(input int sel);
    int n;
    src.set(sel, 1'h1);
    wait_start(LF + 8, n);
    chk(n >= LF && n <= LF + 2, "fast latency");
    chk(start === 4'hF, "units not started together");
    tick(1);
    chk(start === 4'h0, "start longer than a pulse");
    wait_start(30, n);
    chk(n == 30, "held level started twice");
    src.set(sel, 1'h0);
    finish_wave();
    $display("fast test on input %0d done", sel);
  endtask
  task automatic test_slow();
    int n;
    cfg.fast_mode = 1'h0;
    src.place(0);
    wait_start(400, n);
    chk(n >= LS + 157 && n <= LS + 162, "slow latency");
    src.set(0, 1'h0);
    finish_wave();
    cfg.fast_mode = 1'h1;
    $display("slow test done");
  endtask
  task automatic test_jump();
    jump_in = 1'h1;
    tick(1);
    chk(jump === 4'hF, "jump not shared");
    jump_in = 1'h0;
    tick(1);
    chk(jump === 4'h0, "jump stuck");
    $display("jump test done");
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (6000) @(posedge core_clk);
    fails++;
    $display("unexpected at %0t: run hung", $time);
    test_done();
  end
  initial begin
    rst_b = 1'h0;
    wave_end = 1'h0;
    jump_in = 1'h0;
    cfg = '{neg_b: 1'h1, neg_a: 1'h0, fast_mode: 1'h1};
    tick(16);
    chk({clk_o, sync_o, start, jump, busy, hold} === 12'h000, "reset");
    rst_b = 1'h1;
    tick(1);
    test_clocks();
    test_fast(0);
    test_fast(1);
    test_fast(2);
    test_slow();
    test_jump();
    test_done();
  end
endmodule
`default_nettype wire

// >>> tts_edge_det.sv
// single-pulse detector with selectable polarity
// assumes the level is already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module tts_edge_det (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic level,
  input  wire logic neg_pol,
  output logic      pulse
);
  logic act;
  logic prev_r;
  logic prev_nxt;

  // reset high so a level already asserted at reset fires nothing
  always_comb begin
    act      = level ^ neg_pol;
    prev_nxt = act;
    pulse    = act & ~prev_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= prev_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> tts_pkg.sv
// constants and types shared by the trigger timing block
// assumes one core clock whose cycle stands for half a sample clock period
package tts_pkg;

  // *************************************************************
  // clock derivation
  // *************************************************************
  localparam int DIV_RATIO     = 80;
  localparam int DIV_HALF      = DIV_RATIO;
  localparam int SYNC_PERIOD   = 2 * DIV_RATIO;
  localparam int DIV_W         = 7;
  localparam int SCLK_MIN_MHZ  = 6250;
  localparam int SCLK_MAX_MHZ  = 12500;

  // *************************************************************
  // latency and holdoff
  // *************************************************************
  localparam int LAT_FAST_HALF = 32480;
  localparam int LAT_SLOW_HALF = 30880;
  localparam int LAT_W         = 16;
  localparam int CLK_PS        = 25000;
  localparam int HOLDOFF_PS    = 1400000;
  localparam int HOLDOFF_CYC   = (HOLDOFF_PS + CLK_PS - 1) / CLK_PS + 1;
  localparam int HOLD_W        = 7;
  localparam int UNITS         = 4;

  // *************************************************************
  // types
  // *************************************************************
  typedef struct packed {
    logic force_trig;
    logic trig_b;
    logic trig_a;
  } tts_trig_t;

  typedef struct packed {
    logic neg_b;
    logic neg_a;
    logic fast_mode;
  } tts_cfg_t;

  typedef enum logic [1:0] {
    TTS_IDLE,
    TTS_WAIT,
    TTS_PLAY,
    TTS_HOLD
  } tts_state_t;

endpackage

// >>> tts_trig_src.sv
// behavioural trigger source or hub feeding the trigger timing block
// assumes callers change levels just after a rising edge of clk
`timescale 1ns/100ps
`default_nettype none
module tts_trig_src (
  input  wire logic              clk,
  input  wire logic              sync_clk,
  input  wire tts_pkg::tts_cfg_t cfg,
  output var tts_pkg::tts_trig_t trig
);
  logic on_a = 1'h0;
  logic on_b = 1'h0;
  logic on_f = 1'h0;

  // idle level follows polarity, so a negative input rests high
  assign trig = '{force_trig: on_f,
                  trig_b:     on_b ^ cfg.neg_b,
                  trig_a:     on_a ^ cfg.neg_a};

  task automatic set(input int sel, input logic on);
    case (sel)
      0: on_a = on;
      1: on_b = on;
      default: on_f = on;
    endcase
  endtask

  // slow timing: the event lands one core cycle after the sync rise
  task automatic place(input int sel);
    @(posedge sync_clk);
    @(posedge clk);
    #1;
    set(sel, 1'h1);
  endtask
endmodule
`default_nettype wire

// >>> tts_trigger_sync.sv
// trigger capture, timing clock divider and playout start for up to four
// units; assumes one CORE_CLK cycle stands for half a sample clock period
`timescale 1ns/100ps
`default_nettype none
module tts_trigger_sync #(
  parameter int LAT_FAST = tts_pkg::LAT_FAST_HALF,
  parameter int LAT_SLOW = tts_pkg::LAT_SLOW_HALF,
  parameter int NUNITS   = tts_pkg::UNITS
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  input  wire tts_pkg::tts_trig_t TRIG,
  input  wire tts_pkg::tts_cfg_t CFG,
  input  wire logic              WAVE_END,
  input  wire logic              JUMP_IN,
  output logic                   CLK_OUT,
  output logic                   SYNC_CLK_OUT,
  output logic [NUNITS-1:0]      UNIT_START,
  output logic [NUNITS-1:0]      UNIT_JUMP,
  output logic                   BUSY,
  output logic                   HOLDOFF
);

  // *************************************************************
  // clock derivation
  // *************************************************************
  // the sample clock itself is modelled as a toggle per core cycle;
  // valid sample clock range is 6.25 to 12.5 GHz, scaled here
  logic                        clk_r, clk_nxt;
  logic                        sync_r, sync_nxt;
  logic [tts_pkg::DIV_W-1:0]   div_r, div_nxt;
  logic                        strobe;

  always_comb begin
    clk_nxt  = ~clk_r;
    div_nxt  = div_r + 7'h01;
    sync_nxt = sync_r;
    if (div_r == 7'(tts_pkg::DIV_HALF - 1)) begin
      div_nxt  = 7'h00;
      sync_nxt = ~sync_r;
    end
    // fast: every core cycle is one sample clock edge
    strobe = CFG.fast_mode
           | ((div_r == 7'(tts_pkg::DIV_HALF - 1)) & ~sync_r);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      clk_r  <= 1'b0;
      sync_r <= 1'b0;
      div_r  <= 7'h00;
    end else begin
      clk_r  <= clk_nxt;
      sync_r <= sync_nxt;
      div_r  <= div_nxt;
    end
  end

  // *************************************************************
  // trigger detection
  // *************************************************************
  logic edge_a, edge_b, edge_f;

  tts_edge_det u_det_a (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .level   (TRIG.trig_a),
    .neg_pol (CFG.neg_a),
    .pulse   (edge_a)
  );
  tts_edge_det u_det_b (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .level   (TRIG.trig_b),
    .neg_pol (CFG.neg_b),
    .pulse   (edge_b)
  );
  tts_edge_det u_det_f (
    .clk     (CORE_CLK),
    .rst_b   (RST_B),
    .level   (TRIG.force_trig),
    .neg_pol (1'b0),
    .pulse   (edge_f)
  );

  // *************************************************************
  // playout sequencing
  // *************************************************************
  tts_pkg::tts_state_t       st_r, st_nxt;
  logic                      pend_r, pend_nxt;
  logic [tts_pkg::LAT_W-1:0] cnt_r, cnt_nxt;
  logic [tts_pkg::HOLD_W-1:0] hold_r, hold_nxt;
  logic                      start_r, start_nxt;
  logic [NUNITS-1:0]         jump_r, jump_nxt;
  logic                      accept, any_edge;

  function automatic logic [15:0] lat_load(input logic fast);
    lat_load = fast ? 16'(LAT_FAST - 2) : 16'(LAT_SLOW - 2);
  endfunction

  always_comb begin
    any_edge  = edge_a | edge_b | edge_f;
    accept    = strobe & pend_r & (st_r == tts_pkg::TTS_IDLE);
    // set beats the strobe clear unless that strobe accepts; only an idle unit collects triggers,
    // so an edge while busy or in holdoff cannot start a later playout
    pend_nxt  = pend_r;
    if (strobe) begin
      pend_nxt = 1'b0;
    end
    if (any_edge && !accept && (st_r == tts_pkg::TTS_IDLE)) begin
      pend_nxt = 1'b1;
    end
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    hold_nxt  = hold_r;
    start_nxt = 1'b0;
    jump_nxt  = {NUNITS{JUMP_IN}};
    case (st_r)
      tts_pkg::TTS_IDLE: begin
        if (accept) begin
          st_nxt  = tts_pkg::TTS_WAIT;
          cnt_nxt = lat_load(CFG.fast_mode);
        end
      end
      tts_pkg::TTS_WAIT: begin
        if (cnt_r == 16'h0000) begin
          st_nxt    = tts_pkg::TTS_PLAY;
          start_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      tts_pkg::TTS_PLAY: begin
        if (WAVE_END) begin
          st_nxt   = tts_pkg::TTS_HOLD;
          hold_nxt = 7'(tts_pkg::HOLDOFF_CYC - 1);
        end
      end
      tts_pkg::TTS_HOLD: begin
        // edges here never reach the pending flag
        if (hold_r == 7'h00) begin
          st_nxt = tts_pkg::TTS_IDLE;
        end else begin
          hold_nxt = hold_r - 7'h01;
        end
      end
      default: begin
        st_nxt = tts_pkg::TTS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      st_r    <= tts_pkg::TTS_IDLE;
      pend_r  <= 1'b0;
      cnt_r   <= 16'h0000;
      hold_r  <= 7'h00;
      start_r <= 1'b0;
      jump_r  <= '0;
    end else begin
      st_r    <= st_nxt;
      pend_r  <= pend_nxt;
      cnt_r   <= cnt_nxt;
      hold_r  <= hold_nxt;
      start_r <= start_nxt;
      jump_r  <= jump_nxt;
    end
  end

  // *************************************************************
  // outputs
  // *************************************************************
  logic busy_r, hold_o_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      busy_r   <= 1'b0;
      hold_o_r <= 1'b0;
    end else begin
      busy_r   <= (st_nxt != tts_pkg::TTS_IDLE);
      hold_o_r <= (st_nxt == tts_pkg::TTS_HOLD);
    end
  end

  always_comb begin
    CLK_OUT      = clk_r;
    SYNC_CLK_OUT = sync_r;
    UNIT_START   = {NUNITS{start_r}};
    UNIT_JUMP    = jump_r;
    BUSY         = busy_r;
    HOLDOFF      = hold_o_r;
  end

  // *************************************************************
  // assertions
  // *************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_wave_end;
    (st_r == tts_pkg::TTS_PLAY) && WAVE_END;
  endsequence
  sequence s_holding;
    (st_r == tts_pkg::TTS_HOLD) && !pend_r && !accept;
  endsequence

  a_clk_toggle: assert property (1'b1 |=> clk_r != $past(clk_r))
    else $error("clock out did not toggle");
  a_sync_edge: assert property ($changed(sync_r)
      |-> $past(div_r) == 7'(tts_pkg::DIV_HALF - 1))
    else $error("sync clock toggled off count");
  a_slow_strobe: assert property (!CFG.fast_mode && strobe
      |=> $rose(sync_r))
    else $error("slow sampling not on sync rise");
  a_fast_strobe: assert property (CFG.fast_mode && any_edge
      && (st_r == tts_pkg::TTS_IDLE) && !accept
      |=> accept || !CFG.fast_mode)
    else $error("fast mode missed a sampling edge");
  a_pend_kept: assert property (pend_r && !strobe |=> pend_r)
    else $error("pending trigger lost");
  a_accept_wait: assert property (accept
      |=> st_r == tts_pkg::TTS_WAIT && cnt_r == lat_load(CFG.fast_mode))
    else $error("latency not loaded");
  a_start_cause: assert property ($rose(start_r)
      |-> $past(st_r) == tts_pkg::TTS_WAIT && $past(cnt_r) == 16'h0000)
    else $error("start without latency expiry");
  a_hold_ignore: assert property (s_wave_end |=> s_holding[*8])
    else $error("trigger accepted in holdoff");
  a_hold_len: assert property ((st_r == tts_pkg::TTS_HOLD)
      && (hold_r != 7'h00) |=> st_r == tts_pkg::TTS_HOLD)
    else $error("holdoff ended early");
  a_single_pulse: assert property (edge_a |=> !edge_a)
    else $error("trigger pulse longer than one cycle");
  a_force_prop: assert property (edge_f
      |=> pend_r || st_r != tts_pkg::TTS_IDLE)
    else $error("forced trigger dropped");

endmodule
`default_nettype wire
